/* include/adcrs_defs.svh */
// Constants for the converter result-storage block
`ifndef ADCRS_DEFS_SVH
`define ADCRS_DEFS_SVH
`define ADCRS_NCH        10
`define ADCRS_CHW        4
`define ADCRS_RES_W      12
`define ADCRS_ADD2_W     14
`define ADCRS_ADD4_W     16
`define ADCRS_DATA_W     16
`define ADCRS_RST_DATA   16'h0000
`define ADCRS_CNT_ONE    5'h01
`define ADCRS_CNT_W      5
`define ADCRS_TRG_W      2
`define ADCRS_TRG_EXT_A  2'h1
`define ADCRS_TRG_EXT_B  2'h2
`define ADCRS_ADD_NONE   2'h0
`define ADCRS_ADD_2BIT   2'h1
`define ADCRS_ADD_4BIT   2'h2
`define ADCRS_CH_MAX     4'h9
`endif

/* include/adcrs_pkg.sv */
// Types of the converter result-storage block
package adcrs_pkg;
  typedef enum logic [1:0] {
    ADCRS_SCAN_SINGLE,
    ADCRS_SCAN_CONT,
    ADCRS_SCAN_GROUP
  } adcrs_scan_t;
  typedef enum logic [1:0] {
    ADCRS_DST_CHAN,
    ADCRS_DST_DUP,
    ADCRS_DST_EXTA,
    ADCRS_DST_EXTB
  } adcrs_dst_t;
endpackage

/* rtl/adcrs_ram.sv */
// Small memory holding the per-channel result words
`timescale 1ns/1ps
`default_nettype none
module adcrs_ram #(
  parameter int DEPTH = 10,
  parameter int AW    = 4,
  parameter int DW    = 16
) (
  input  wire logic          clock,
  input  wire logic          sys_rst,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output var  logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem_r [DEPTH];
  logic [DW-1:0] rd_r;
  logic [DW-1:0] rd_nxt;

  // Read word picked combinationally, then registered
  always_comb begin
    rd_nxt = (rd_addr < AW'(DEPTH)) ? mem_r[rd_addr] : '0;
  end

  // Entries change only when written; reset clears them
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      rd_r <= '0;
    end else begin
      if (wr_en && (wr_addr < AW'(DEPTH))) begin
        mem_r[wr_addr] <= wr_data;
      end
      rd_r <= rd_nxt;
    end
  end

  assign rd_data = rd_r;
endmodule
`default_nettype wire

/* rtl/adcrs_acc.sv */
// Addition-mode accumulator widening the stored sum
`timescale 1ns/1ps
`default_nettype none
`include "adcrs_defs.svh"
module adcrs_acc #(
  parameter int RW = 12,
  parameter int DW = 16
) (
  input  wire logic          clock,
  input  wire logic          sys_rst,
  input  wire logic          clr,
  input  wire logic          add,
  input  wire logic [RW-1:0] sample,
  input  wire logic [1:0]    add_mode,
  output var  logic [DW-1:0] sum
);
  logic [DW-1:0] sum_r;
  logic [DW-1:0] sum_nxt;
  logic [DW-1:0] base;

  // Sum restarts on clr so each channel accumulates alone
  always_comb begin
    base    = clr ? '0 : sum_r;
    sum_nxt = sum_r;
    if (add) begin
      sum_nxt = base + DW'(sample);
    end else if (clr) begin
      sum_nxt = '0;
    end
    // Clip to 2 extra bits in 2-bit mode; 4-bit sums are bounded only by the DW width
    if (add_mode == `ADCRS_ADD_2BIT) begin
      sum_nxt = sum_nxt & DW'({`ADCRS_ADD2_W{1'b1}});
    end
  end

  // Accumulator register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sum_r <= '0;
    end else begin
      sum_r <= sum_nxt;
    end
  end

  assign sum = sum_nxt;
endmodule
`default_nettype wire

/* rtl/adcrs_top.sv */
// Result storage for a 12-bit successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
`include "adcrs_defs.svh"
module adcrs_top
  import adcrs_pkg::*;
#(
  // Sizes; defaults match the documented converter
  parameter int NCH = `ADCRS_NCH,
  parameter int RW  = `ADCRS_RES_W,
  parameter int DW  = `ADCRS_DATA_W,
  parameter int CW  = `ADCRS_CHW
) (
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  // Scan and storage configuration
  input  wire adcrs_pkg::adcrs_scan_t        scan_mode,
  input  wire logic                          dbl_trig_en,
  input  wire logic                          ext_dbl_en,
  input  wire logic [CW-1:0]                 dbl_chan,
  input  wire logic [1:0]                    add_mode,
  input  wire logic [`ADCRS_CNT_W-1:0]       add_count,
  input  wire logic                          scan_start,
  input  wire logic                          scan_group_b,
  input  wire logic [`ADCRS_TRG_W-1:0]       trig_src,
  input  wire logic [NCH-1:0]                grp_a_sel,
  input  wire logic [NCH-1:0]                grp_b_sel,
  // Results offered by the converter core
  input  wire logic                          res_valid,
  input  wire logic [CW-1:0]                 res_chan,
  input  wire logic [RW-1:0]                 res_data,
  input  wire logic                          diag_valid,
  input  wire logic [RW-1:0]                 diag_data,
  input  wire logic                          vref_valid,
  input  wire logic [RW-1:0]                 vref_data,
  // Software read side
  input  wire logic [CW-1:0]                 rd_chan,
  output var  logic [DW-1:0]                 rd_data,
  output var  logic [DW-1:0]                 dup_data,
  output var  logic [DW-1:0]                 dup_ext_a,
  output var  logic [DW-1:0]                 dup_ext_b,
  output var  logic [DW-1:0]                 diag_result,
  output var  logic [DW-1:0]                 vref_result,
  output var  logic [NCH-1:0]                conv_req,
  output var  logic                          scan_busy,
  output var  logic                          dbl_mode_act
);
  import adcrs_pkg::*;

  // ************************************************
  // Helpers
  // ************************************************
  // Trigger source eligible for extended storage
  function automatic logic ext_trig(input logic [`ADCRS_TRG_W-1:0] t);
    ext_trig = (t == `ADCRS_TRG_EXT_A) || (t == `ADCRS_TRG_EXT_B);
  endfunction

  // ************************************************
  // Scan sequencing
  // ************************************************
  // Sequencer state
  logic [NCH-1:0]            pend_r;
  logic [NCH-1:0]            pend_nxt;
  logic                      busy_r;
  logic                      busy_nxt;
  logic                      dbl_act_r;
  logic                      dbl_act_nxt;
  logic                      second_r;
  logic                      second_nxt;
  logic [`ADCRS_TRG_W-1:0]   trg_r;
  logic [`ADCRS_TRG_W-1:0]   trg_nxt;
  logic [`ADCRS_CNT_W-1:0]   cnt_r;
  logic [`ADCRS_CNT_W-1:0]   cnt_nxt;
  logic                      last_add;
  logic                      add_on;
  logic                      chan_ok;
  logic                      take;
  adcrs_dst_t                dst;

  // Qualifiers shared by the sequencer, the accumulator and the stores
  assign add_on   = (add_mode != `ADCRS_ADD_NONE);
  assign chan_ok  = (res_chan <= `ADCRS_CH_MAX);
  assign last_add = !add_on || (cnt_r >= add_count);
  // A start in the same cycle wins, so that result is dropped everywhere
  assign take     = res_valid && chan_ok && busy_r && !scan_start;

  // Pending set: each chosen input retires on its last sample; continuous scan refills, the others go idle
  always_comb begin
    pend_nxt    = pend_r;
    busy_nxt    = busy_r;
    dbl_act_nxt = dbl_act_r;
    second_nxt  = second_r;
    trg_nxt     = trg_r;
    cnt_nxt     = cnt_r;
    if (scan_start) begin
      // Double trigger refused in continuous scan
      dbl_act_nxt = dbl_trig_en && (scan_mode != ADCRS_SCAN_CONT);
      trg_nxt     = trig_src;
      busy_nxt    = 1'b1;
      cnt_nxt     = `ADCRS_CNT_ONE;
      unique case (scan_mode)
        ADCRS_SCAN_SINGLE: pend_nxt = grp_a_sel;
        ADCRS_SCAN_CONT:   pend_nxt = grp_a_sel;
        ADCRS_SCAN_GROUP:  pend_nxt = scan_group_b ? grp_b_sel : grp_a_sel;
        default:           pend_nxt = grp_a_sel; // Unused code runs as single scan
      endcase
    end else if (take) begin
      // Channel retires only when its last summed sample arrives
      if (last_add) begin
        cnt_nxt = `ADCRS_CNT_ONE;
        pend_nxt[res_chan] = 1'b0;
        // Chosen channel alternates first and second result
        if (dbl_act_r && (res_chan == dbl_chan)) begin
          second_nxt = !second_r;
        end
        // Continuous scan refills; the other modes go idle when empty
        if ((pend_nxt == '0) && (scan_mode == ADCRS_SCAN_CONT)) begin
          pend_nxt = grp_a_sel;
        end else if (pend_nxt == '0) begin
          busy_nxt = 1'b0;
        end
      end else begin
        // Partial sum: the channel stays pending
        cnt_nxt = cnt_r + `ADCRS_CNT_ONE;
      end
    end
  end

  // Sequencing registers
  // Counter rests at one so the next sample opens a fresh sum
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pend_r    <= '0;
      busy_r    <= 1'b0;
      dbl_act_r <= 1'b0;
      second_r  <= 1'b0;
      trg_r     <= '0;
      cnt_r     <= `ADCRS_CNT_ONE;
    end else begin
      pend_r    <= pend_nxt;
      busy_r    <= busy_nxt;
      dbl_act_r <= dbl_act_nxt;
      second_r  <= second_nxt;
      trg_r     <= trg_nxt;
      cnt_r     <= cnt_nxt;
    end
  end

  // ************************************************
  // Destination choice
  // ************************************************
  // Extended routing only for eligible triggers, else first/second split
  always_comb begin
    dst = ADCRS_DST_CHAN;
    if (dbl_act_r && (res_chan == dbl_chan)) begin
      // Designated triggers bypass the first/second split
      if (ext_dbl_en && ext_trig(trg_r)) begin
        dst = (trg_r == `ADCRS_TRG_EXT_A) ? ADCRS_DST_EXTA : ADCRS_DST_EXTB;
      // Any other trigger keeps plain double trigger behaviour
      end else if (second_r) begin
        dst = ADCRS_DST_DUP;
      end
    end
  end

  // ************************************************
  // Accumulation and channel storage
  // ************************************************
  // Sum and store signals
  logic [DW-1:0] acc_sum;
  logic [DW-1:0] store_val;
  logic          ch_wr;
  logic          acc_clr;
  logic          acc_add;

  // First taken sample of each channel restarts the sum
  assign acc_clr = take && (cnt_r == `ADCRS_CNT_ONE);
  assign acc_add = take;

  adcrs_acc #(
    .RW (RW),
    .DW (DW)
  ) u_acc (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .clr      (acc_clr),
    .add      (acc_add),
    .sample   (res_data),
    .add_mode (add_mode),
    .sum      (acc_sum)
  );

  // Plain mode keeps 12 bits; addition keeps the widened sum
  assign store_val = add_on ? acc_sum : DW'(res_data);
  // Duplicated results leave the channel word alone
  assign ch_wr = take && last_add && (dst == ADCRS_DST_CHAN);

  // One word per channel; untouched words hold their value
  // Out-of-range read channels return zero from the memory itself
  adcrs_ram #(
    .DEPTH (NCH),
    .AW    (CW),
    .DW    (DW)
  ) u_ram (
    .clock   (clock),
    .sys_rst (sys_rst),
    .wr_en   (ch_wr),
    .wr_addr (res_chan),
    .wr_data (store_val),
    .rd_addr (rd_chan),
    .rd_data (rd_data)
  );

  // ************************************************
  // Dedicated result registers
  // ************************************************
  // Dedicated result words and their next values
  logic [DW-1:0] dup_r;
  logic [DW-1:0] dup_nxt;
  logic [DW-1:0] exa_r;
  logic [DW-1:0] exa_nxt;
  logic [DW-1:0] exb_r;
  logic [DW-1:0] exb_nxt;
  logic [DW-1:0] diag_r;
  logic [DW-1:0] diag_nxt;
  logic [DW-1:0] vref_r;
  logic [DW-1:0] vref_nxt;
  logic          fin;

  // A channel finishes on its last summed sample
  assign fin = take && last_add;

  // Each register loads only on its own event, else holds
  always_comb begin
    dup_nxt  = dup_r;
    exa_nxt  = exa_r;
    exb_nxt  = exb_r;
    diag_nxt = diag_r;
    vref_nxt = vref_r;
    // Finished results go where the destination choice sends them
    if (fin) begin
      unique case (dst)
        ADCRS_DST_CHAN: ;
        ADCRS_DST_DUP:  dup_nxt = store_val;
        ADCRS_DST_EXTA: exa_nxt = store_val;
        ADCRS_DST_EXTB: exb_nxt = store_val;
      endcase
    end
    // Side readings load whenever the core offers them
    if (diag_valid) begin
      diag_nxt = DW'(diag_data);
    end
    if (vref_valid) begin
      vref_nxt = DW'(vref_data);
    end
  end

  // Dedicated registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dup_r  <= `ADCRS_RST_DATA;
      exa_r  <= `ADCRS_RST_DATA;
      exb_r  <= `ADCRS_RST_DATA;
      diag_r <= `ADCRS_RST_DATA;
      vref_r <= `ADCRS_RST_DATA;
    end else begin
      dup_r  <= dup_nxt;
      exa_r  <= exa_nxt;
      exb_r  <= exb_nxt;
      diag_r <= diag_nxt;
      vref_r <= vref_nxt;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  // Every output is a register; no logic after the flops
  assign dup_data     = dup_r;
  assign dup_ext_a    = exa_r;
  assign dup_ext_b    = exb_r;
  assign diag_result  = diag_r;
  assign vref_result  = vref_r;

  // Sequencer state seen by the core and by software
  assign conv_req     = pend_r;
  assign scan_busy    = busy_r;
  assign dbl_mode_act = dbl_act_r;
endmodule
`default_nettype wire

/* verif/adcrs_core_model.sv */
// Behavioural converter core feeding results to the storage block
`timescale 1ns/1ps
`default_nettype none
module adcrs_core_model (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [9:0]  conv_req,
  input  wire logic [3:0]  dly,
  input  wire logic [11:0] base,
  output var  logic        res_valid,
  output var  logic [3:0]  res_chan,
  output var  logic [11:0] res_data
);
  logic [3:0] ch;
  // Serve lowest pending channel; lines carry junk between results
  initial begin
    res_valid = 1'b0;
    res_chan = 4'h0;
    res_data = 12'h000;
    forever begin
      @(posedge clock);
      #1;
      if (!sys_rst && conv_req != 10'h000) begin
        for (int i = 9; i >= 0; i--) begin
          if (conv_req[i]) ch = 4'(i);
        end
        repeat (dly) @(posedge clock);
        #1;
        res_valid = 1'b1;
        res_chan = ch;
        res_data = base + 12'(ch);
        @(posedge clock);
        #1;
        res_valid = 1'b0;
        res_chan = ~ch;  // Inverted so a stale value never looks valid
        res_data = ~res_data;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/adcrs_top_sva.sv */
// Checker for the converter result-storage block
`timescale 1ns/1ps
`default_nettype none
module adcrs_chk
  import adcrs_pkg::*;
#(
  parameter int NCH = 10,
  parameter int RW  = 12,
  parameter int DW  = 16,
  parameter int CW  = 4
) (
  input wire logic                   clock,
  input wire logic                   sys_rst,
  input wire adcrs_pkg::adcrs_scan_t scan_mode,
  input wire logic                   scan_start,
  input wire logic                   ext_dbl_en,
  input wire logic                   scan_group_b,
  input wire logic [NCH-1:0]         grp_a_sel,
  input wire logic [NCH-1:0]         grp_b_sel,
  input wire logic [1:0]             add_mode,
  input wire logic                   res_valid,
  input wire logic [CW-1:0]          res_chan,
  input wire logic                   diag_valid,
  input wire logic [RW-1:0]          diag_data,
  input wire logic                   vref_valid,
  input wire logic [RW-1:0]          vref_data,
  input wire logic [CW-1:0]          rd_chan,
  input wire logic [DW-1:0]          rd_data,
  input wire logic [DW-1:0]          dup_data,
  input wire logic [DW-1:0]          dup_ext_a,
  input wire logic [DW-1:0]          dup_ext_b,
  input wire logic [DW-1:0]          diag_result,
  input wire logic [DW-1:0]          vref_result,
  input wire logic [NCH-1:0]         conv_req,
  input wire logic                   scan_busy,
  input wire logic                   dbl_mode_act
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // Side registers take their sample one cycle on and keep it
  a_diag_store: assert property (diag_valid |=> diag_result == $past(diag_data))
    else $error("diag result not stored");
  a_vref_store: assert property (vref_valid |=> vref_result == $past(vref_data))
    else $error("vref result not stored");
  a_diag_hold: assert property (!diag_valid |=> $stable(diag_result))
    else $error("diag result changed");
  a_vref_hold: assert property (!vref_valid |=> $stable(vref_result))
    else $error("vref result changed");
  // Scan start and completion, and out-of-range reads
  a_cont_no_dbl: assert property (scan_start && scan_mode == ADCRS_SCAN_CONT |=>
      !dbl_mode_act) else $error("double trigger in continuous scan");
  a_start_single: assert property (scan_start && scan_mode == ADCRS_SCAN_SINGLE |=>
      conv_req == $past(grp_a_sel) && scan_busy) else $error("single start wrong");
  a_start_group: assert property (scan_start && scan_mode == ADCRS_SCAN_GROUP |=>
      conv_req == ($past(scan_group_b) ? $past(grp_b_sel) : $past(grp_a_sel)))
    else $error("group start wrong");
  a_req_clear: assert property (res_valid && scan_busy && res_chan <= 4'h9
      && !scan_start && scan_mode == ADCRS_SCAN_SINGLE && add_mode == 2'h0
      |=> !conv_req[$past(res_chan)]) else $error("served channel still pending");
  a_idle_stay: assert property (!scan_busy && !scan_start |=> !scan_busy)
    else $error("busy without start");
  a_rd_range: assert property (rd_chan > 4'h9 |=> rd_data == '0)
    else $error("read beyond channels not zero");
  // Duplicate words move only on a finished result of the right kind
  a_dup_hold: assert property (!res_valid |=>
      $stable(dup_data) && $stable(dup_ext_a) && $stable(dup_ext_b))
    else $error("duplicate word changed without a result");
  a_dup_needs_dbl: assert property (!dbl_mode_act |=> $stable(dup_data))
    else $error("duplicate loaded outside double trigger");
  a_ext_needs_en: assert property (!ext_dbl_en |=>
      $stable(dup_ext_a) && $stable(dup_ext_b)) else $error("extended word loaded while off");
  c_single: cover property (scan_start && scan_mode == ADCRS_SCAN_SINGLE);
  c_group: cover property (scan_start && scan_mode == ADCRS_SCAN_GROUP);
  c_result: cover property (res_valid && scan_busy);
  c_dbl_dup: cover property (res_valid && scan_busy && dbl_mode_act);
  c_add_sum: cover property (res_valid && scan_busy && add_mode != 2'h0);
endmodule
bind adcrs_top adcrs_chk #(.NCH(NCH), .RW(RW), .DW(DW), .CW(CW)) i_adcrs_chk (.clock,
  .sys_rst, .scan_mode, .scan_start, .scan_group_b, .grp_a_sel, .grp_b_sel, .add_mode,
  .res_valid, .res_chan, .diag_valid, .diag_data, .vref_valid, .vref_data, .rd_chan,
  .rd_data, .dup_data, .dup_ext_a, .dup_ext_b, .ext_dbl_en, .diag_result, .vref_result,
  .conv_req, .scan_busy, .dbl_mode_act);
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the converter result-storage block
`timescale 1ns/1ps
`default_nettype none
`include "adcrs_defs.svh"
module tb;
  import adcrs_pkg::*;
  typedef struct {logic [9:0] sel; logic [11:0] base; logic [3:0] dly;} adcrs_row_t;
  adcrs_row_t  rows [3] = '{'{10'h3FF, 12'h100, 4'h0}, '{10'h201, 12'hA00, 4'h5},
                            '{10'h040, 12'hFF0, 4'h2}};
  logic        clock, sys_rst, scan_start, scan_group_b, dbl_trig_en, ext_dbl_en;
  logic        diag_valid, vref_valid, scan_busy, dbl_mode_act, res_valid;
  adcrs_scan_t scan_mode;
  logic [1:0]  add_mode, trig_src;
  logic [4:0]  add_count;
  logic [3:0]  dbl_chan, rd_chan, res_chan, dly;
  logic [9:0]  grp_a_sel, grp_b_sel, conv_req;
  logic [11:0] res_data, diag_data, vref_data, base;
  logic [15:0] rd_data, dup_data, dup_ext_a, dup_ext_b, diag_result, vref_result;
  logic [15:0] exp_r [10];
  int          bad_count, n_compared, cycles;
  adcrs_top i_adcrs_top (.clock, .sys_rst, .scan_mode, .dbl_trig_en, .ext_dbl_en, .dbl_chan,
    .add_mode, .add_count, .scan_start, .scan_group_b, .trig_src, .grp_a_sel, .grp_b_sel,
    .res_valid, .res_chan, .res_data, .diag_valid, .diag_data, .vref_valid, .vref_data,
    .rd_chan, .rd_data, .dup_data, .dup_ext_a, .dup_ext_b, .diag_result, .vref_result,
    .conv_req, .scan_busy, .dbl_mode_act);
  adcrs_core_model i_adcrs_core_model (.clock, .sys_rst, .conv_req, .dly, .base,
    .res_valid, .res_chan, .res_data);
  // Clock and hang guard
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [3:0] ch, input logic [15:0] exp);
    rd_chan = ch;
    tick(1);
    check(rd_data, exp);
  endtask
  // One scan, waiting for busy to drop under a bound
  task automatic run_scan(input adcrs_scan_t m, input logic [9:0] a, input logic [9:0] b);
    int k = 0;
    scan_mode = m;
    grp_a_sel = a;
    grp_b_sel = b;
    scan_start = 1'b1;
    tick(1);
    scan_start = 1'b0;
    while (scan_busy !== 1'b0 && k < 400) begin
      tick(1);
      k++;
    end
    check(scan_busy, 1'b0);
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence: table rows, then the awkward cases
  initial begin
    {scan_start, scan_group_b, dbl_trig_en, ext_dbl_en, diag_valid, vref_valid} = '0;
    {add_mode, trig_src, add_count, dbl_chan, rd_chan, dly} = '0;
    {grp_a_sel, grp_b_sel, diag_data, vref_data, base} = '0;
    scan_mode = ADCRS_SCAN_SINGLE;
    foreach (exp_r[c]) exp_r[c] = 16'h0000;
    sys_rst = 1'b1;
    tick(10);
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      base = rows[i].base;
      dly = rows[i].dly;
      run_scan(ADCRS_SCAN_SINGLE, rows[i].sel, ~rows[i].sel);
      for (int c = 0; c < 10; c++) begin
        if (rows[i].sel[c]) exp_r[c] = {4'h0, base + 12'(c)};
        rd(4'(c), exp_r[c]);
      end
      $display("row %0d done", i);
    end
    rd(4'hA, 16'h0000);
    rd(4'hF, 16'h0000);
    diag_valid = 1'b1;
    diag_data = 12'hFFF;
    vref_valid = 1'b1;
    vref_data = 12'h5A5;
    tick(1);
    {diag_valid, vref_valid, diag_data, vref_data} = '0;
    tick(3);
    check(diag_result, 16'h0FFF);
    check(vref_result, 16'h05A5);
    $display("side registers done");
    scan_group_b = 1'b1;
    base = 12'h300;
    run_scan(ADCRS_SCAN_GROUP, 10'h001, 10'h0C0);
    scan_group_b = 1'b0;
    rd(4'h0, exp_r[0]);
    rd(4'h6, 16'h0306);
    rd(4'h7, 16'h0307);
    $display("group scan done");
    dbl_trig_en = 1'b1;
    dbl_chan = 4'h2;
    base = 12'h111;
    run_scan(ADCRS_SCAN_SINGLE, 10'h004, 10'h000);
    base = 12'h222;
    run_scan(ADCRS_SCAN_SINGLE, 10'h004, 10'h000);
    rd(4'h2, 16'h0113);
    check(dup_data, 16'h0224);
    ext_dbl_en = 1'b1;
    trig_src = `ADCRS_TRG_EXT_A;
    base = 12'h400;
    run_scan(ADCRS_SCAN_SINGLE, 10'h004, 10'h000);
    trig_src = `ADCRS_TRG_EXT_B;
    base = 12'h500;
    run_scan(ADCRS_SCAN_SINGLE, 10'h004, 10'h000);
    check(dup_ext_a, 16'h0402);
    check(dup_ext_b, 16'h0502);
    trig_src = 2'h3;
    base = 12'h600;
    run_scan(ADCRS_SCAN_GROUP, 10'h004, 10'h000);
    base = 12'h700;
    run_scan(ADCRS_SCAN_GROUP, 10'h004, 10'h000);
    rd(4'h2, 16'h0602);
    check(dup_data, 16'h0702);
    check(dup_ext_a, 16'h0402);
    check(dbl_mode_act, 1'b1);
    {dbl_trig_en, ext_dbl_en, trig_src} = '0;
    $display("double trigger done");
    base = 12'hFFC;
    add_mode = `ADCRS_ADD_2BIT;
    add_count = 5'h04;
    run_scan(ADCRS_SCAN_SINGLE, 10'h008, 10'h000);
    rd(4'h3, 16'h3FFC);
    add_mode = `ADCRS_ADD_4BIT;
    add_count = 5'h10;
    run_scan(ADCRS_SCAN_SINGLE, 10'h008, 10'h000);
    rd(4'h3, 16'hFFF0);
    add_mode = `ADCRS_ADD_NONE;
    $display("addition done");
    dbl_trig_en = 1'b1;
    scan_mode = ADCRS_SCAN_CONT;
    grp_a_sel = 10'h001;
    scan_start = 1'b1;
    tick(1);
    scan_start = 1'b0;
    tick(4);
    check(dbl_mode_act, 1'b0);
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    check(rd_data | dup_data | dup_ext_a | dup_ext_b | diag_result | vref_result, 16'h0000);
    check({scan_busy, conv_req}, 16'h0000);
    $display("reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
